// >>> tdep_port.sv
// Test access port controller with open-drain debug event pin
//
// Operation
// - Test data in is captured at each rising test clock edge in shift-IR or shift-DR.
// - Test mode select is captured at each rising test clock edge and steps the controller.
// - Test data out is driven only in shift-IR or shift-DR, otherwise released, also in reset.
// - Test data out changes at the falling test clock edge.
// - Test reset initialises the controller at on_chip_debug_module, without a test clock edge.
// - Undriven data in, mode select, test reset and debug event pins read as high.
// - An outside pull on the debug event pin makes the core finish, save, halt and await commands.
// - On debug entry by request or breakpoint the event pin is asserted for exactly three cycles.
// - The event pin is open-drain: pulled low to acknowledge entry, else released.
// - Besides the event pin all debug module access goes through the serial test port.
`timescale 1ns/1ps
`default_nettype none

module tdep_port
  import tdep_pkg::*;
#(
  parameter int unsigned IR_W = TDEP_IR_W,
  parameter int unsigned DR_W = TDEP_DR_W
) (
  input  wire logic            sys_clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            tck_i,
  input  wire logic            tdi_i,
  input  wire logic            tms_i,
  input  wire logic            trst_n_i,
  output logic                 tdo_o,
  output logic                 tdo_oe_o,
  input  wire logic            debug_event_pin_i,
  output logic                 debug_event_pin_o,
  output logic                 debug_event_pin_oe_o,
  input  wire logic            core_instr_done_i,
  input  wire logic            breakpoint_hit_i,
  output logic                 core_halt_req_o,
  output logic                 core_debug_mode_o,
  input  wire logic            core_resume_i,
  output logic [IR_W-1:0]      dbg_instr_o,
  output logic [DR_W-1:0]      dbg_data_o,
  output logic                 dbg_update_o,
  input  wire logic [DR_W-1:0] dbg_capture_i
);

  // ==========================================================================
  // Pin synchronisers; pins other than the test clock float high through the pull-ups
  logic tck_rise, tck_fall;
  logic tdi_lvl, tms_lvl, trst_n_lvl, de_lvl;

  // Test clock chain resets low, its idle level, so no edge follows reset
  tdep_sync #(.RST_VAL(TDEP_TCK_SYNC_RST)) u_sync_tck (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .pin_i(tck_i), .level_o(), .rise_o(tck_rise), .fall_o(tck_fall));
  tdep_sync u_sync_tdi (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(tdi_i),
    .level_o(tdi_lvl), .rise_o(), .fall_o());
  tdep_sync u_sync_tms (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(tms_i),
    .level_o(tms_lvl), .rise_o(), .fall_o());
  tdep_sync u_sync_trs (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(trst_n_i),
    .level_o(trst_n_lvl), .rise_o(), .fall_o());
  tdep_sync u_sync_de (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(debug_event_pin_i), .level_o(de_lvl), .rise_o(), .fall_o());

  // ==========================================================================
  // Test controller
  tdep_tap_state_t state;
  tdep_tap_state_t next_state;
  logic            trst_act;

  // Test reset acts without waiting for a test clock edge
  assign trst_act = ~trst_n_lvl;

  always_comb begin
    case (state)
      TDEP_TLR:  next_state = tms_lvl ? TDEP_TLR  : TDEP_RTI;
      TDEP_RTI:  next_state = tms_lvl ? TDEP_SDRS : TDEP_RTI;
      TDEP_SDRS: next_state = tms_lvl ? TDEP_SIRS : TDEP_CDR;
      TDEP_CDR:  next_state = tms_lvl ? TDEP_E1DR : TDEP_SDR;
      TDEP_SDR:  next_state = tms_lvl ? TDEP_E1DR : TDEP_SDR;
      TDEP_E1DR: next_state = tms_lvl ? TDEP_UDR  : TDEP_PDR;
      TDEP_PDR:  next_state = tms_lvl ? TDEP_E2DR : TDEP_PDR;
      TDEP_E2DR: next_state = tms_lvl ? TDEP_UDR  : TDEP_SDR;
      TDEP_UDR:  next_state = tms_lvl ? TDEP_SDRS : TDEP_RTI;
      TDEP_SIRS: next_state = tms_lvl ? TDEP_TLR  : TDEP_CIR;
      TDEP_CIR:  next_state = tms_lvl ? TDEP_E1IR : TDEP_SIR;
      TDEP_SIR:  next_state = tms_lvl ? TDEP_E1IR : TDEP_SIR;
      TDEP_E1IR: next_state = tms_lvl ? TDEP_UIR  : TDEP_PIR;
      TDEP_PIR:  next_state = tms_lvl ? TDEP_E2IR : TDEP_PIR;
      TDEP_E2IR: next_state = tms_lvl ? TDEP_UIR  : TDEP_SIR;
      TDEP_UIR:  next_state = tms_lvl ? TDEP_SDRS : TDEP_RTI;
      default:   next_state = TDEP_TLR;
    endcase
  end

  // Mode select steps the machine on each sampled rising test clock edge
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= TDEP_TLR;
    end else if (trst_act) begin
      state <= TDEP_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Instruction and data shift registers
  logic [IR_W-1:0] ir_sh;
  logic [DR_W-1:0] dr_sh;
  logic            in_shift;
  logic            shift_bit;

  assign in_shift  = (state == TDEP_SDR) | (state == TDEP_SIR);
  assign shift_bit = (state == TDEP_SIR) ? ir_sh[0] : dr_sh[0];

  // Data in is taken at the rising edge while shifting
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ir_sh        <= '0;
      dr_sh        <= '0;
      dbg_instr_o  <= TDEP_IR_RST;
      dbg_data_o   <= '0;
      dbg_update_o <= 1'b0;
    end else begin
      dbg_update_o <= 1'b0;
      if (trst_act) begin
        dbg_instr_o <= TDEP_IR_RST;
      end else if (tck_rise) begin
        case (state)
          TDEP_CIR: ir_sh <= TDEP_IR_RST;
          TDEP_SIR: ir_sh <= {tdi_lvl, ir_sh[IR_W-1:1]};
          TDEP_UIR: dbg_instr_o <= ir_sh;
          TDEP_CDR: dr_sh <= dbg_capture_i;
          TDEP_SDR: dr_sh <= {tdi_lvl, dr_sh[DR_W-1:1]};
          TDEP_UDR: begin
            dbg_data_o   <= dr_sh;
            dbg_update_o <= 1'b1;
          end
          default: ir_sh <= ir_sh;
        endcase
      end
    end
  end

  // ==========================================================================
  // Test data out; value moves only on falling edges, drive also drops on test reset
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdo_o    <= 1'b1;
      tdo_oe_o <= 1'b0;
    end else if (trst_act) begin
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o    <= shift_bit;
      tdo_oe_o <= in_shift;
    end
  end

  // ==========================================================================
  // Debug entry: an outside low on the event pin or a breakpoint
  logic       halt_pend;
  logic [1:0] ack_cnt;
  logic       entry;

  // Entry happens on_chip_debug_module the current instruction has retired
  assign entry = halt_pend & core_instr_done_i & ~core_debug_mode_o;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halt_pend         <= 1'b0;
      core_halt_req_o   <= 1'b0;
      core_debug_mode_o <= 1'b0;
    end else begin
      if (entry) begin
        core_debug_mode_o <= 1'b1;
      end else if (core_resume_i) begin
        core_debug_mode_o <= 1'b0;
      end
      // Request wins over its own completion so a fresh pull is kept
      if ((~de_lvl & ~debug_event_pin_oe_o) | breakpoint_hit_i) begin
        halt_pend <= ~core_debug_mode_o;
      end else if (entry) begin
        halt_pend <= 1'b0;
      end
      core_halt_req_o <= halt_pend & ~core_debug_mode_o;
    end
  end

  // Open-drain acknowledge, three system cycles low
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_cnt              <= '0;
      debug_event_pin_oe_o <= 1'b0;
    end else if (entry) begin
      ack_cnt              <= TDEP_ACK_CNT_W1;
      debug_event_pin_oe_o <= 1'b1;
    end else if (ack_cnt != '0) begin
      ack_cnt <= ack_cnt - 2'h1;
    end else begin
      debug_event_pin_oe_o <= 1'b0;
    end
  end

  assign debug_event_pin_o = 1'b0; // pulled low only, never driven high

  // ==========================================================================
  // Checks
  property p_ack_len;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      entry |=> debug_event_pin_oe_o [*3] ##1 !debug_event_pin_oe_o;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack not 3 cycles");

  property p_tdo_only_shift;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(tdo_oe_o) |-> in_shift && $past(tck_fall);
  endproperty
  a_tdo_only_shift: assert property (p_tdo_only_shift) else $error("tdo on outside shift");

  property p_tdo_fall;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $changed(tdo_o) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge");

  property p_trst;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      trst_act |=> state == TDEP_TLR && !tdo_oe_o;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");

  property p_step;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !trst_act && !tck_rise |=> $stable(state);
  endproperty
  a_step: assert property (p_step) else $error("state moved without clock");

  property p_tms_tlr;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      state == TDEP_SIRS && tms_lvl && tck_rise && !trst_act |=> state == TDEP_TLR;
  endproperty
  a_tms_tlr: assert property (p_tms_tlr) else $error("bad tap step");

  property p_sdr_in;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      state == TDEP_SDR && tck_rise && !trst_act |=> dr_sh[DR_W-1] == $past(tdi_lvl);
  endproperty
  a_sdr_in: assert property (p_sdr_in) else $error("tdi not captured");

  property p_od;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      debug_event_pin_oe_o |-> !debug_event_pin_o;
  endproperty
  a_od: assert property (p_od) else $error("event pin driven high");

  property p_entry;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      entry |=> core_debug_mode_o;
  endproperty
  a_entry: assert property (p_entry) else $error("debug mode not entered");

  c_entry: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) entry);
  c_shift_dr: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) state == TDEP_SDR);
  c_update_ir: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) state == TDEP_UIR);
  c_bp: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) breakpoint_hit_i && entry);

endmodule : tdep_port
`default_nettype wire

// >>> tdep_pkg.sv
// Package: constants and state encodings for the test and debug event port
package tdep_pkg;

  // ==========================================================================
  // Test controller states, one-hot
  typedef enum logic [15:0] {
    TDEP_TLR   = 16'h0001,
    TDEP_RTI   = 16'h0002,
    TDEP_SDRS  = 16'h0004,
    TDEP_CDR   = 16'h0008,
    TDEP_SDR   = 16'h0010,
    TDEP_E1DR  = 16'h0020,
    TDEP_PDR   = 16'h0040,
    TDEP_E2DR  = 16'h0080,
    TDEP_UDR   = 16'h0100,
    TDEP_SIRS  = 16'h0200,
    TDEP_CIR   = 16'h0400,
    TDEP_SIR   = 16'h0800,
    TDEP_E1IR  = 16'h1000,
    TDEP_PIR   = 16'h2000,
    TDEP_E2IR  = 16'h4000,
    TDEP_UIR   = 16'h8000
  } tdep_tap_state_t;

  // ==========================================================================
  // Widths, reset values and timing
  localparam int unsigned TDEP_IR_W        = 4;
  localparam int unsigned TDEP_DR_W        = 32;
  localparam logic [3:0]  TDEP_IR_RST      = 4'hf;  // Bypass after reset
  localparam int unsigned TDEP_ACK_CYCLES  = 3;     // Debug entry pulse length
  localparam logic [1:0]  TDEP_ACK_CNT_W1  = 2'h2;  // Load value for 3-cycle pulse
  localparam logic [2:0]  TDEP_SYNC_RST    = 3'h7;  // Pins idle high (pull-ups)
  localparam logic [2:0]  TDEP_TCK_SYNC_RST = 3'h0; // Test clock idles low

endpackage : tdep_pkg

// >>> tdep_sync.sv
// Three-flop input synchroniser with edge detection on agreeing stages
`timescale 1ns/1ps
`default_nettype none

module tdep_sync
  import tdep_pkg::*;
#(
  parameter logic [2:0] RST_VAL = TDEP_SYNC_RST
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] stage;
  logic       lvl;
  logic       agree;

  // ==========================================================================
  // Shift chain; stage[0] feeds only stage[1]
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage <= RST_VAL;
    end else begin
      stage <= {stage[1:0], pin_i};
    end
  end

  // Change counts only on_chip_debug_module stage 1 and stage 2 agree, so a single
  // unsettled sample can never be taken as an edge
  assign agree = ~(stage[1] ^ stage[2]);

  // Settled level; starts at the pin's idle level to avoid a false edge
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl <= RST_VAL[2];
    end else if (agree) begin
      lvl <= stage[2];
    end
  end

  assign level_o = lvl;
  assign rise_o  = agree & stage[2] & ~lvl;
  assign fall_o  = agree & ~stage[2] & lvl;

endmodule : tdep_sync
`default_nettype wire

// >>> tdep_host.sv
// Test controller model: drives the serial test pins from the system clock
`timescale 1ns/1ps
`default_nettype none

module tdep_host (
  input  wire logic sys_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output var logic  tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output var logic  trst_n_o
);
  // ==========================================================================
  // Pins; a released line reads at its pull-up level
  logic drv = 1'b0;
  logic tms_q = 1'b1;
  logic tdi_q = 1'b1;
  initial tck_o = 1'b0;
  initial trst_n_o = 1'b1;
  assign tms_o = drv ? tms_q : 1'b1;
  assign tdi_o = drv ? tdi_q : 1'b1;

  // One test clock period of 320 ns; tdo is read just before the fall
  // Only the serial port is used to reach the debug logic
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
    @(posedge sys_clk_i);
    drv <= 1'b1;
    tms_q <= tms;
    tdi_q <= tdi;
    repeat (3) @(posedge sys_clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    tdo = tdo_i;
    oe = tdo_oe_i;
    tck_o <= 1'b0;
  endtask

  // Release the data pins between frames; the test clock stays low
  task automatic idle();
    @(posedge sys_clk_i);
    drv <= 1'b0;
  endtask

  // Test reset pulse with the test clock standing still
  task automatic tap_reset();
    @(posedge sys_clk_i);
    trst_n_o <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    trst_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule // tdep_host
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the test access port and debug event pin
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tdep_pkg::*;
  typedef struct packed { logic [31:0] cap; logic [31:0] din; } tdep_row_t;
  logic                 sys_clk_i, sys_rst_i, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic                 dep_o, dep_oe, ext_pull, dep_line, done, bp, halt, dmode, resume, upd;
  logic [TDEP_IR_W-1:0] instr;
  logic [TDEP_DR_W-1:0] data, cap, got;
  logic                 t, o;
  int                   err_count = 0;
  int                   n_checks = 0;
  int                   oe_cnt = 0;
  int                   upd_cnt = 0;
  tdep_row_t            rows [3] = '{'{32'h8000_0001, 32'h1234_abcd},
                                     '{32'hffff_ffff, 32'h0000_0000},
                                     '{32'h5a5a_0f0f, 32'hc3c3_f00f}};

  // ==========================================================================
  // Open-drain event line with pull-up, shared with the outside party
  assign dep_line = (dep_oe ? dep_o : 1'b1) & ~ext_pull;

  tdep_port u_tdep_port (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck),
    .tdi_i(tdi), .tms_i(tms), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .debug_event_pin_i(dep_line), .debug_event_pin_o(dep_o),
    .debug_event_pin_oe_o(dep_oe), .core_instr_done_i(done), .breakpoint_hit_i(bp),
    .core_halt_req_o(halt), .core_debug_mode_o(dmode), .core_resume_i(resume),
    .dbg_instr_o(instr), .dbg_data_o(data), .dbg_update_o(upd), .dbg_capture_i(cap));
  tdep_host u_tdep_host (.sys_clk_i(sys_clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));

  // ==========================================================================
  // Clock and pulse counters; counting cycles catches stretched pulses
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (dep_oe === 1'b1)
      oe_cnt++;
    if (upd === 1'b1)
      upd_cnt++;
  end

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    int u;
    dout = '0;
    u = upd_cnt;
    u_tdep_host.step(1'b0, 1'b1, t, o);
    u_tdep_host.step(1'b1, 1'b1, t, o);
    if (ir)
      u_tdep_host.step(1'b1, 1'b1, t, o);
    u_tdep_host.step(1'b0, 1'b1, t, o);
    u_tdep_host.step(1'b0, 1'b1, t, o);
    check(o === 1'b0, "tdo driven before shift");
    for (int i = 0; i < n; i++) begin
      u_tdep_host.step(i == n - 1, din[i], t, o);
      check(o === 1'b1, "tdo released in shift");
      dout[i] = t;
    end
    u_tdep_host.step(1'b1, 1'b1, t, o);
    check(o === 1'b0, "tdo driven after shift");
    u_tdep_host.step(1'b0, 1'b1, t, o);
    u_tdep_host.idle();
    repeat (8) @(posedge sys_clk_i);
    if (!ir)
      check(upd_cnt - u == 1, "update pulse length");
  endtask

  // Debug entry by pin pull or breakpoint, then resume
  task automatic dbg_entry(input logic by_bp);
    int c0;
    int w;
    c0 = oe_cnt;
    @(posedge sys_clk_i);
    ext_pull <= ~by_bp;
    bp <= by_bp;
    for (w = 0; w < 20 && halt !== 1'b1; w++)
      @(negedge sys_clk_i);
    check(halt === 1'b1 && dmode === 1'b0, "no halt request before retire");
    if (halt !== 1'b1)
      summarize();
    // Current instruction retires only now; entry must wait for it
    @(posedge sys_clk_i);
    done <= 1'b1;
    for (w = 0; w < 20 && dmode !== 1'b1; w++)
      @(negedge sys_clk_i);
    check(dmode === 1'b1, "no debug entry");
    if (dmode !== 1'b1)
      summarize();
    check(dep_oe === 1'b1 && dep_line === 1'b0, "event pin not pulled low");
    @(posedge sys_clk_i);
    ext_pull <= 1'b0;
    bp <= 1'b0;
    repeat (12) @(negedge sys_clk_i);
    check(oe_cnt - c0 == TDEP_ACK_CYCLES, "event pulse length");
    check(dmode === 1'b1 && dep_line === 1'b1 && halt === 1'b0, "debug mode not held");
    @(posedge sys_clk_i);
    resume <= 1'b1;
    done <= 1'b0;
    @(posedge sys_clk_i);
    resume <= 1'b0;
    repeat (6) @(negedge sys_clk_i);
    check(dmode === 1'b0 && halt === 1'b0 && oe_cnt - c0 == TDEP_ACK_CYCLES, "resume failed");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    ext_pull = 1'b0;
    done = 1'b0;
    bp = 1'b0;
    resume = 1'b0;
    cap = '0;
    repeat (10) @(negedge sys_clk_i);
    check(tdo_oe === 1'b0 && instr === TDEP_IR_RST, "reset state");
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    u_tdep_host.tap_reset();
    foreach (rows[k]) begin
      cap <= rows[k].cap;
      scan(1'b0, TDEP_DR_W, rows[k].din, got);
      check(got === rows[k].cap, "captured data out");
      check(data === rows[k].din, "shifted data in");
      $display("data row %0d done", k);
    end
    scan(1'b1, TDEP_IR_W, 32'h5, got);
    check(got[TDEP_IR_W-1:0] === TDEP_IR_RST && instr === 4'h5, "instruction shift");
    $display("instruction test done");
    for (int j = 0; j < 5; j++)
      u_tdep_host.step(j == 1, 1'b0, t, o);
    check(o === 1'b1, "shift state not reached");
    u_tdep_host.idle();
    u_tdep_host.tap_reset();
    check(tdo_oe === 1'b0 && instr === TDEP_IR_RST, "test reset ignored");
    $display("test reset done");
    dbg_entry(1'b0);
    dbg_entry(1'b1);
    $display("debug event tests done");
    summarize();
  end

  // Bound on the whole run
  initial begin
    #3000000;
    err_count++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end
endmodule // tb
`default_nettype wire
